// ---- verilog/pll_synth_pkg.sv ----
// Package with widths, positions and types of the synthesizer core.
package pll_synth_pkg;
  localparam int REF_W      = 14;
  localparam int SWAL_W     = 7;
  localparam int PROG_W     = 10;
  localparam int MAIN_W     = SWAL_W + PROG_W;
  localparam int SHIFT_W    = MAIN_W + 1;
  localparam int SEL_POS    = 0;
  localparam int SWAL_LSB   = 1;
  localparam int PROG_LSB   = SWAL_LSB + SWAL_W;
  localparam int REF_LSB    = 1;
  localparam int LOCK_W     = 4;
  localparam logic [REF_W-1:0]  REF_RESET  = 14'h0005;
  localparam logic [PROG_W-1:0] PROG_RESET = 10'h005;
  localparam logic [SWAL_W-1:0] SWAL_RESET = 7'h00;
  localparam logic [LOCK_W-1:0] LOCK_GOOD  = 4'hF;

  typedef struct packed {
    logic [PROG_W-1:0] prog;
    logic [SWAL_W-1:0] swal;
  } main_word_t;

  typedef enum logic [1:0] {
    PD_IDLE = 2'b00,
    PD_UP   = 2'b01,
    PD_DOWN = 2'b10
  } pd_state_t;
endpackage : pll_synth_pkg

// ---- verilog/pll_synth_core.sv ----
// Serial-programmed frequency synthesizer digital core.
`timescale 1ns/1ps
module pll_synth_core (
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  input  wire logic CLK_EN,
  input  wire logic CRYSTAL_AMP_INPUT,
  input  wire logic PRESCALER_IN,
  input  wire logic SERIAL_CLK,
  input  wire logic SERIAL_DATA,
  input  wire logic LOAD_STROBE,
  output logic      MODULUS_CTRL,
  output logic      PUMP_OUT,
  output logic      PUMP_OE,
  output logic      LOCK_DETECT_OUT,
  output logic      MAIN_DIV_MONITOR,
  output logic      REF_DIV_MONITOR
);
  localparam int RW = pll_synth_pkg::REF_W;
  localparam int SW = pll_synth_pkg::SWAL_W;
  localparam int PW = pll_synth_pkg::PROG_W;
  localparam int HW = pll_synth_pkg::SHIFT_W;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      prev_reg  <= 5'h00;
    end else if (CLK_EN) begin
      sync1_reg <= {CRYSTAL_AMP_INPUT, PRESCALER_IN, SERIAL_CLK,
                    SERIAL_DATA, LOAD_STROBE};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  logic osc_rise;
  logic pre_rise;
  logic pre_fall;
  logic sck_rise;
  logic sdata;
  logic strobe;
  assign osc_rise = sync2_reg[4] & ~prev_reg[4];
  assign pre_rise = sync2_reg[3] & ~prev_reg[3];
  assign pre_fall = ~sync2_reg[3] & prev_reg[3];
  // Data is sampled one stage later than the clock edge seen here.
  assign sck_rise = sync2_reg[2] & ~prev_reg[2];
  assign sdata    = prev_reg[1];
  assign strobe   = sync2_reg[0];

  // ------------------------------------------------------------
  // Serial shift register and latches
  // ------------------------------------------------------------
  logic [HW-1:0] shift_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_reg <= '0;
    end else if (CLK_EN && sck_rise) begin
      shift_reg <= {shift_reg[HW-2:0], sdata};
    end
  end

  logic [RW-1:0]             ref_latch_reg;
  pll_synth_pkg::main_word_t main_latch_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_latch_reg       <= pll_synth_pkg::REF_RESET;
      main_latch_reg.prog <= pll_synth_pkg::PROG_RESET;
      main_latch_reg.swal <= pll_synth_pkg::SWAL_RESET;
    end else if (CLK_EN && strobe) begin
      if (shift_reg[pll_synth_pkg::SEL_POS]) begin
        ref_latch_reg <= shift_reg[pll_synth_pkg::REF_LSB +: RW];
      end else begin
        main_latch_reg.swal <= shift_reg[pll_synth_pkg::SWAL_LSB +: SW];
        main_latch_reg.prog <= shift_reg[pll_synth_pkg::PROG_LSB +: PW];
      end
    end
  end

  // ------------------------------------------------------------
  // Reference divider
  // ------------------------------------------------------------
  logic [RW-1:0] ref_cnt_reg;
  logic          ref_pulse;
  assign ref_pulse = osc_rise && (ref_cnt_reg <= 14'h0001);
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_cnt_reg <= pll_synth_pkg::REF_RESET;
    end else if (CLK_EN && osc_rise) begin
      if (ref_pulse) begin
        ref_cnt_reg <= ref_latch_reg;
      end else begin
        ref_cnt_reg <= ref_cnt_reg - 14'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Pulse swallow main divider
  // ------------------------------------------------------------
  logic [PW-1:0] prog_cnt_reg;
  logic [SW-1:0] swal_cnt_reg;
  logic          main_pulse;
  assign main_pulse = pre_rise && (prog_cnt_reg <= 10'h001);
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prog_cnt_reg <= pll_synth_pkg::PROG_RESET;
      swal_cnt_reg <= pll_synth_pkg::SWAL_RESET;
    end else if (CLK_EN && pre_rise) begin
      if (main_pulse) begin
        prog_cnt_reg <= main_latch_reg.prog;
        swal_cnt_reg <= main_latch_reg.swal;
      end else begin
        prog_cnt_reg <= prog_cnt_reg - 10'h001;
        if (swal_cnt_reg != 7'h00) begin
          swal_cnt_reg <= swal_cnt_reg - 7'h01;
        end
      end
    end
  end

  // Low selects modulus plus one while swallowing remains.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MODULUS_CTRL <= 1'b1;
    end else if (CLK_EN && pre_fall) begin
      MODULUS_CTRL <= (swal_cnt_reg == 7'h00);
    end
  end

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MAIN_DIV_MONITOR <= 1'b0;
      REF_DIV_MONITOR  <= 1'b0;
    end else if (CLK_EN) begin
      MAIN_DIV_MONITOR <= main_pulse;
      REF_DIV_MONITOR  <= ref_pulse;
    end
  end

  // ------------------------------------------------------------
  // Phase detector and charge pump
  // ------------------------------------------------------------
  pll_synth_pkg::pd_state_t pd_reg;
  pll_synth_pkg::pd_state_t pd_next;
  always_comb begin
    pd_next = pd_reg;
    case (pd_reg)
      pll_synth_pkg::PD_IDLE: begin
        if (ref_pulse && !main_pulse) begin
          pd_next = pll_synth_pkg::PD_UP;
        end else if (main_pulse && !ref_pulse) begin
          pd_next = pll_synth_pkg::PD_DOWN;
        end
      end
      pll_synth_pkg::PD_UP: begin
        if (main_pulse) begin
          pd_next = pll_synth_pkg::PD_IDLE;
        end
      end
      pll_synth_pkg::PD_DOWN: begin
        if (ref_pulse) begin
          pd_next = pll_synth_pkg::PD_IDLE;
        end
      end
      default: pd_next = pll_synth_pkg::PD_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_reg <= pll_synth_pkg::PD_IDLE;
    end else if (CLK_EN) begin
      pd_reg <= pd_next;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PUMP_OUT <= 1'b0;
      PUMP_OE  <= 1'b0;
    end else if (CLK_EN) begin
      PUMP_OUT <= (pd_next == pll_synth_pkg::PD_UP);
      PUMP_OE  <= (pd_next != pll_synth_pkg::PD_IDLE);
    end
  end

  // ------------------------------------------------------------
  // Lock detect
  // ------------------------------------------------------------
  logic [pll_synth_pkg::LOCK_W-1:0] lock_cnt_reg;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_cnt_reg <= '0;
    end else if (CLK_EN) begin
      if (pd_reg != pll_synth_pkg::PD_IDLE) begin
        lock_cnt_reg <= '0;
      end else if (ref_pulse && lock_cnt_reg != pll_synth_pkg::LOCK_GOOD) begin
        lock_cnt_reg <= lock_cnt_reg + 4'h1;
      end
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LOCK_DETECT_OUT <= 1'b0;
    end else if (CLK_EN) begin
      // Low while the detector is pumping, then until the lock count climbs back to LOCK_GOOD.
      LOCK_DETECT_OUT <= (pd_next == pll_synth_pkg::PD_IDLE) &&
                         (lock_cnt_reg == pll_synth_pkg::LOCK_GOOD);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  mod_on_fall_a: assert property (
    CLK_EN && !$stable(MODULUS_CTRL) |-> $past(pre_fall))
    else $error("modulus control moved off a prescaler fall");
  mod_level_a: assert property (
    CLK_EN && pre_fall |=> MODULUS_CTRL == ($past(swal_cnt_reg) == 7'h00))
    else $error("modulus control level wrong");
  mod_plus_a: assert property (
    CLK_EN && pre_fall && swal_cnt_reg != 7'h00 |=> !MODULUS_CTRL)
    else $error("modulus control not low while swallowing");
  shift_in_a: assert property (
    CLK_EN && sck_rise |=> shift_reg[0] == $past(sdata))
    else $error("serial bit not shifted in");
  ref_load_a: assert property (
    CLK_EN && strobe && shift_reg[0] |=>
      ref_latch_reg == $past(shift_reg[RW:1]))
    else $error("reference latch not loaded");
  main_load_a: assert property (
    CLK_EN && strobe && !shift_reg[0] |=>
      main_latch_reg == $past(shift_reg[HW-1:1]))
    else $error("main latch not loaded");
  ref_reload_a: assert property (
    CLK_EN && ref_pulse |=> ref_cnt_reg == $past(ref_latch_reg))
    else $error("reference counter reload wrong");
  main_mon_a: assert property (
    CLK_EN |=> MAIN_DIV_MONITOR == $past(main_pulse))
    else $error("main monitor mismatch");
  pump_float_a: assert property (
    CLK_EN && pd_next == pll_synth_pkg::PD_IDLE |=> !PUMP_OE)
    else $error("pump not floating when idle");
  lock_low_a: assert property (
    CLK_EN && pd_next != pll_synth_pkg::PD_IDLE |=> !LOCK_DETECT_OUT)
    else $error("lock high while pumping");
  ref_mon_a: assert property (
    CLK_EN |=> REF_DIV_MONITOR == $past(ref_pulse))
    else $error("reference monitor mismatch");
  main_reload_a: assert property (
    CLK_EN && main_pulse |=> prog_cnt_reg == $past(main_latch_reg.prog))
    else $error("programmable counter reload wrong");
  swal_load_a: assert property (
    CLK_EN && main_pulse |=> swal_cnt_reg == $past(main_latch_reg.swal))
    else $error("swallow counter reload wrong");
  pump_drive_a: assert property (
    CLK_EN && pd_next == pll_synth_pkg::PD_UP |=> PUMP_OE && PUMP_OUT)
    else $error("pump not driving high");
  pump_sink_a: assert property (
    CLK_EN && pd_next == pll_synth_pkg::PD_DOWN |=> PUMP_OE && !PUMP_OUT)
    else $error("pump not sinking low");
  latch_hold_a: assert property (
    CLK_EN && !strobe |=>
      $stable(ref_latch_reg) && $stable(main_latch_reg))
    else $error("latch changed without strobe");
  lock_rise_a: assert property (
    CLK_EN && pd_next == pll_synth_pkg::PD_IDLE &&
      lock_cnt_reg == pll_synth_pkg::LOCK_GOOD |=> LOCK_DETECT_OUT)
    else $error("lock not reported when locked");

  up_cover_c: cover property (pd_reg == pll_synth_pkg::PD_UP);
  down_cover_c: cover property (pd_reg == pll_synth_pkg::PD_DOWN);
  lock_cover_c: cover property (LOCK_DETECT_OUT);
  swal_cover_c: cover property (!MODULUS_CTRL ##[1:200] MODULUS_CTRL);
  freeze_cover_c: cover property (!CLK_EN ##1 CLK_EN);
endmodule : pll_synth_core

// ---- tb/prescaler_model.sv ----
// Behavioural dual-modulus prescaler that feeds the core's divider input.
`timescale 1ns/1ps
module prescaler_model #(
  parameter int HIGH_T   = 4,
  parameter int LOW_BASE = 6
) (
  input  wire logic clk,
  input  wire logic mod_ctrl,
  output logic      pre_out
);
  // ----------------------------------------------------------------
  // Output waveform
  // ----------------------------------------------------------------
  int cnt = 0;
  int low_t = LOW_BASE;

  initial pre_out = 1'b0;

  // The modulus is chosen at each rise, when the control has settled.
  always @(negedge clk) begin
    cnt = cnt + 1;
    if (pre_out && cnt >= HIGH_T) begin
      pre_out = 1'b0;
      cnt = 0;
    end else if (!pre_out && cnt >= low_t) begin
      pre_out = 1'b1;
      cnt = 0;
      low_t = mod_ctrl ? LOW_BASE : LOW_BASE + 1;
    end
  end
endmodule : prescaler_model

// ---- tb/tb_top.sv ----
// Self-checking testbench for the synthesizer core.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, rst_n = 0, xtal = 0, sclk = 0, sdata = 0, strb = 0;
  logic pre, mod_ctrl, pump_out, pump_oe, lock, main_mon, ref_mon;
  logic clk_en = 1, x_follow = 0, mon_q = 0, xtal_pin;
  logic pre_q = 0, x_q = 0, up_seen = 0, dn_seen = 0, lo_seen = 0;
  int   n_mismatch = 0, checks_done = 0, pre_cnt = 0, low_cnt = 0;
  int   x_cnt = 0, n_seen = 0, a_seen = 0, r_seen = 0, n_mon = 0;

  // The crystal pin can follow the prescaler so both dividers run in phase.
  assign xtal_pin = x_follow ? pre : xtal;

  pll_synth_core pll_synth_core_inst (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en),
    .CRYSTAL_AMP_INPUT(xtal_pin), .PRESCALER_IN(pre), .SERIAL_CLK(sclk),
    .SERIAL_DATA(sdata), .LOAD_STROBE(strb), .MODULUS_CTRL(mod_ctrl),
    .PUMP_OUT(pump_out), .PUMP_OE(pump_oe), .LOCK_DETECT_OUT(lock),
    .MAIN_DIV_MONITOR(main_mon), .REF_DIV_MONITOR(ref_mon));

  prescaler_model prescaler_model_inst (
    .clk(ref_clk), .mod_ctrl(mod_ctrl), .pre_out(pre));

  // ----------------------------------------------------------------
  // Clocks and measurement
  // ----------------------------------------------------------------
  initial forever #25 ref_clk = ~ref_clk;
  initial forever begin
    repeat (5) @(negedge ref_clk);
    xtal = ~xtal;
  end

  // Counts input periods between monitor pulses and notes pump states.
  always @(posedge ref_clk) begin
    pre_q <= pre;
    x_q <= xtal;
    mon_q <= main_mon;
    if (main_mon && !mon_q) n_mon++;
    if (pre && !pre_q) begin
      pre_cnt++;
      if (!mod_ctrl) low_cnt++;
    end
    if (xtal && !x_q) x_cnt++;
    if (main_mon) begin
      n_seen = pre_cnt; a_seen = low_cnt; pre_cnt = 0; low_cnt = 0;
    end
    if (ref_mon) begin
      r_seen = x_cnt; x_cnt = 0;
    end
    if (pump_oe && pump_out) up_seen = 1;
    if (pump_oe && !pump_out) dn_seen = 1;
    if (!lock) lo_seen = 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Shifts nb bits MSB first, select bit last, then strobes the latch.
  task load(input logic [17:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      @(negedge ref_clk); sdata = w[i];
      repeat (4) @(negedge ref_clk); sclk = 1;
      repeat (4) @(negedge ref_clk); sclk = 0;
    end
    sdata = ~w[0];
    repeat (4) @(negedge ref_clk); strb = 1;
    repeat (6) @(negedge ref_clk); strb = 0;
  endtask : load

  task test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_main;
    load({10'd6, 7'd2, 1'b0}, 18);
    repeat (220) @(negedge ref_clk);
    check("main_periods", n_seen, 6);
    check("swallow_periods", a_seen, 2);
    $display("main divider test ended");
  endtask : t_main

  task t_ref;
    load({3'h0, 14'd7, 1'b1}, 15);
    repeat (250) @(negedge ref_clk);
    check("ref_periods", r_seen, 7);
    check("main_kept", n_seen, 6);
    $display("reference divider test ended");
  endtask : t_ref

  task t_pump;
    load({3'h0, 14'd5, 1'b1}, 15);
    load({10'd10, 7'd0, 1'b0}, 18);
    up_seen = 0; dn_seen = 0; lo_seen = 0;
    repeat (600) @(negedge ref_clk);
    check("pump_drive", up_seen, 1);
    check("lock_pulses", lo_seen, 1);
    load({3'h0, 14'd12, 1'b1}, 15);
    load({10'd5, 7'd0, 1'b0}, 18);
    dn_seen = 0;
    repeat (600) @(negedge ref_clk);
    check("pump_sink", dn_seen, 1);
    load({3'h0, 14'd5, 1'b1}, 15);
    // A reset with both inputs on one waveform lines the dividers up.
    x_follow = 1;
    rst_n = 0;
    repeat (2) @(negedge ref_clk);
    check("rst_ctrl", mod_ctrl, 1'b1);
    check("rst_lock", lock, 1'b0);
    check("rst_pump_oe", pump_oe, 1'b0);
    rst_n = 1;
    repeat (1500) @(negedge ref_clk);
    check("lock_high", lock, 1'b1);
    check("pump_float", pump_oe, 1'b0);
    $display("pump and lock test ended");
  endtask : t_pump

  task t_freeze;
    int base;
    clk_en = 0;
    repeat (2) @(negedge ref_clk);
    base = n_mon;
    repeat (200) @(negedge ref_clk);
    check("frozen_mon", n_mon, base);
    check("frozen_lock", lock, 1'b1);
    clk_en = 1;
    repeat (200) @(negedge ref_clk);
    check("resumed_mon", n_mon > base, 1'b1);
    check("resumed_lock", lock, 1'b1);
    $display("clock enable test ended");
  endtask : t_freeze

  initial begin
    repeat (3) @(negedge ref_clk);
    check("reset_ctrl", mod_ctrl, 1'b1);
    check("reset_pump_oe", pump_oe, 1'b0);
    check("reset_main_mon", main_mon, 1'b0);
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    t_main;
    t_ref;
    t_pump;
    t_freeze;
    test_done;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    test_done;
  end
endmodule : tb_top
